// ### rtl/ctb_regs.sv
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
// Operation
// - Interval timing parameters are 16-bit two's complement counts of 20.48 us.
// - In interval timer test mode those parameters count 80 ns units.
// - Noise limit is a 16-bit two's complement count of 0.32 us.
// - In noise timer test mode the noise limit counts 80 ns units.
// - Software programs all timing registers; each reads back at any time.
// - Minimum connect time register sits at index 06.
// - Minimum line-state transmit time register sits at index 07.
// - Minimum break time register sits at index 08.
// - Signaling timeout register sits at index 09.
// - Link confidence test length register sits at index 0B.
// - Scrub time register sits at index 0C.
// - Noise limit register sits at index 0D.
// - Transmit vector at index 03 is read/write and cleared by reset.
// - Vector write during signaling is dropped and sets the access error flag.
// - Bits go out one at a time: one as Halt, zero as Master.
// - Bit 0 first, ascending, stopping after the programmed length.
// - An accepted vector write sets the signaling-active flag.
// - Length field holds bit count minus one, 0..15 meaning 1..16.
// - Timers load two's complement, count up, expire on reaching zero.
// - While bit n goes out, received bit n is captured, Halt one.
module ctb_regs
	import ctb_pkg::*;
#(
	parameter int TICK_CYC = BASE_TICK_CYC
) (
	// Clock and reset
	input  wire logic        clock_i,
	input  wire logic        arst_n_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Line state from the receiver, asynchronous
	input  wire logic        rx_halt_i,
	input  wire logic        rx_master_i,
	input  wire logic        line_noise_i,
	// Line state to the transmitter and status
	output logic             tx_halt_o,
	output logic             tx_master_o,
	output logic             signaling_o,
	output logic             noise_expired_o
);

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	if (TICK_CYC < 1 || TICK_CYC > 15) begin : g_bad_tick
		$error("ctb_regs: TICK_CYC must lie in 1..15");
	end

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic                                 pready;
		logic                                 pslverr;
		logic [31:0]                          prdata;
		logic [PARAM_W-1:0]                   vec_out;
		logic [LEN_W-1:0]                     vec_len;
		logic [PARAM_W-1:0]                   vec_in;
		logic [N_PARAMS-1:0][PARAM_W-1:0]     params;
		logic                                 ct_test;
		logic                                 nt_test;
		logic                                 access_err;
		logic                                 signaling;
		logic [LEN_W-1:0]                     bit_idx;
		logic                                 tx_halt;
		logic                                 tx_master;
		logic [3:0]                           base_cnt;
		logic [PARAM_W-1:0]                   ct_cnt;
		logic [CT_DIV_W-1:0]                  ct_div;
		logic [PARAM_W-1:0]                   nt_cnt;
		logic [NT_DIV_W-1:0]                  nt_div;
		logic                                 nt_run;
		logic                                 noise_expired;
		logic                                 halt_s1;
		logic                                 halt_s2;
		logic                                 master_s1;
		logic                                 master_s2;
		logic                                 noise_s1;
		logic                                 noise_s2;
		logic                                 noise_prev;
	} ctb_state_t;

	ctb_state_t st;
	ctb_state_t next_st;

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	logic [5:0]  idx;
	logic        aligned;
	logic        setup_acc;
	logic        done;
	logic        wr_done;
	logic        rd_done;
	logic        mapped;
	logic [31:0] rd_val;
	logic        base_tick;
	logic        ct_tick;
	logic        ct_expire;
	logic        nt_tick;
	logic        nt_expire;
	logic        vec_wr;
	logic        len_wr;
	logic        noise_rise;

	assign idx       = paddr_i[7:2];
	assign aligned   = (paddr_i[1:0] == ADDR_ALIGN);
	assign setup_acc = psel_i & penable_i & ~st.pready;
	// The write lands on the edge where the master sees pready high
	assign done      = psel_i & penable_i & st.pready;
	assign wr_done   = done & pwrite_i & ~st.pslverr;
	assign rd_done   = done & ~pwrite_i & ~st.pslverr;

	always_comb begin
		mapped = aligned;
		rd_val = RDATA_NONE;
		case (idx)
			IDX_VEC_OUT:   rd_val[PARAM_W-1:0] = st.vec_out;
			IDX_VEC_LEN:   rd_val[LEN_W-1:0]   = st.vec_len;
			IDX_CONN_HOLD: rd_val[PARAM_W-1:0] = st.params[P_CONN_HOLD];
			IDX_LS_SEND:   rd_val[PARAM_W-1:0] = st.params[P_LS_SEND];
			IDX_BREAK:     rd_val[PARAM_W-1:0] = st.params[P_BREAK];
			IDX_SIG_TOUT:  rd_val[PARAM_W-1:0] = st.params[P_SIG_TOUT];
			IDX_CONF_LEN:  rd_val[PARAM_W-1:0] = st.params[P_CONF_LEN];
			IDX_SCRUB:     rd_val[PARAM_W-1:0] = st.params[P_SCRUB];
			IDX_NOISE:     rd_val[PARAM_W-1:0] = st.params[P_NOISE];
			IDX_CONTROL: begin
				rd_val[CTRL_CT16_BIT] = st.ct_test;
				rd_val[CTRL_NT16_BIT] = st.nt_test;
			end
			IDX_STATUS: begin
				rd_val[STAT_SIG_BIT]   = st.signaling;
				rd_val[STAT_NOISE_BIT] = st.nt_run;
			end
			IDX_VEC_IN:    rd_val[PARAM_W-1:0] = st.vec_in;
			IDX_EVENT:     rd_val[EVT_ERR_BIT] = st.access_err;
			default:       mapped = 1'b0;
		endcase
		if (!aligned) begin
			rd_val = RDATA_NONE;
		end
	end

	// ****************************************************************
	// Timer ticks
	// ****************************************************************
	// The clock is not a multiple of 80 ns, so each base tick is rounded up
	assign base_tick = (st.base_cnt == 4'(TICK_CYC - 1));
	// Test mode bypasses the divider: one count per base tick
	assign ct_tick   = base_tick & (st.ct_test | (&st.ct_div));
	assign ct_expire = st.signaling & ct_tick & (&st.ct_cnt);
	assign nt_tick   = base_tick & (st.nt_test | (&st.nt_div));
	assign nt_expire = st.nt_run & nt_tick & (&st.nt_cnt);

	assign vec_wr     = wr_done & (idx == IDX_VEC_OUT);
	assign len_wr     = wr_done & (idx == IDX_VEC_LEN);
	assign noise_rise = st.noise_s2 & ~st.noise_prev;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		next_st = st;

		// Synchronisers: first stage feeds only the second
		next_st.halt_s1    = rx_halt_i;
		next_st.halt_s2    = st.halt_s1;
		next_st.master_s1  = rx_master_i;
		next_st.master_s2  = st.master_s1;
		next_st.noise_s1   = line_noise_i;
		next_st.noise_s2   = st.noise_s1;
		next_st.noise_prev = st.noise_s2;

		// Bus answer: one wait state, then pready for one cycle
		next_st.pready  = setup_acc;
		next_st.pslverr = setup_acc & ~mapped;
		next_st.prdata  = setup_acc ? rd_val : RDATA_NONE;

		// Base tick prescaler
		next_st.base_cnt = base_tick ? 4'h0 : st.base_cnt + 4'h1;

		// Software writes
		if (wr_done) begin
			case (idx)
				IDX_CONN_HOLD: next_st.params[P_CONN_HOLD] = pwdata_i[PARAM_W-1:0];
				IDX_LS_SEND:   next_st.params[P_LS_SEND]   = pwdata_i[PARAM_W-1:0];
				IDX_BREAK:     next_st.params[P_BREAK]     = pwdata_i[PARAM_W-1:0];
				IDX_SIG_TOUT:  next_st.params[P_SIG_TOUT]  = pwdata_i[PARAM_W-1:0];
				IDX_CONF_LEN:  next_st.params[P_CONF_LEN]  = pwdata_i[PARAM_W-1:0];
				IDX_SCRUB:     next_st.params[P_SCRUB]     = pwdata_i[PARAM_W-1:0];
				IDX_NOISE:     next_st.params[P_NOISE]     = pwdata_i[PARAM_W-1:0];
				IDX_CONTROL: begin
					next_st.ct_test = pwdata_i[CTRL_CT16_BIT];
					next_st.nt_test = pwdata_i[CTRL_NT16_BIT];
				end
				default: begin
				end
			endcase
		end

		// Event register clears on read; a fresh error in the same edge wins
		if (rd_done && idx == IDX_EVENT) begin
			next_st.access_err = 1'b0;
		end

		// Vector length: refused while signaling, like the vector itself
		if (len_wr) begin
			if (st.signaling) begin
				next_st.access_err = 1'b1;
			end else begin
				next_st.vec_len = pwdata_i[LEN_W-1:0];
			end
		end

		// ************************************************************
		// Bit signaling
		// ************************************************************
		// A refused write only flags the error, so the running bit timer never stalls
		if (vec_wr && st.signaling) begin
			next_st.access_err = 1'b1;
		end
		if (vec_wr && !st.signaling) begin
			// Length must already be programmed: signaling starts now
			next_st.vec_out   = pwdata_i[PARAM_W-1:0];
			next_st.signaling = 1'b1;
			next_st.bit_idx   = LEN_RESET;
			next_st.tx_halt   = pwdata_i[0];
			next_st.tx_master = ~pwdata_i[0];
			next_st.ct_cnt    = st.params[P_LS_SEND];
			next_st.ct_div    = '0;
		end else if (st.signaling) begin
			if (ct_tick) begin
				next_st.ct_cnt = st.ct_cnt + 16'h0001;
			end
			if (base_tick) begin
				next_st.ct_div = st.ct_div + 8'h01;
			end
			if (ct_expire) begin
				// Only a clean Halt counts as one; Master or a torn state reads as zero
				next_st.vec_in[st.bit_idx] = st.halt_s2 & ~st.master_s2;
				next_st.ct_cnt = st.params[P_LS_SEND];
				next_st.ct_div = '0;
				if (st.bit_idx == st.vec_len) begin
					// Last bit sent: drop signaling and release the line
					next_st.signaling = 1'b0;
					next_st.tx_halt   = 1'b0;
					next_st.tx_master = 1'b0;
				end else begin
					next_st.bit_idx   = st.bit_idx + 4'h1;
					next_st.tx_halt   = st.vec_out[st.bit_idx + 4'h1];
					next_st.tx_master = ~st.vec_out[st.bit_idx + 4'h1];
				end
			end
		end

		// ************************************************************
		// Noise duration timer
		// ************************************************************
		next_st.noise_expired = nt_expire;
		if (noise_rise) begin
			next_st.nt_run = 1'b1;
			next_st.nt_cnt = st.params[P_NOISE];
			next_st.nt_div = '0;
		end else if (!st.noise_s2 || nt_expire) begin
			next_st.nt_run = 1'b0;
		end else if (st.nt_run) begin
			if (nt_tick) begin
				next_st.nt_cnt = st.nt_cnt + 16'h0001;
			end
			if (base_tick) begin
				next_st.nt_div = st.nt_div + 2'h1;
			end
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign prdata_o        = st.prdata;
	assign pready_o        = st.pready;
	assign pslverr_o       = st.pslverr;
	assign tx_halt_o       = st.tx_halt;
	assign tx_master_o     = st.tx_master;
	assign signaling_o     = st.signaling;
	assign noise_expired_o = st.noise_expired;

endmodule

// ### include/ctb_pkg.sv
package ctb_pkg;

	// ****************************************************************
	// Register indices; the byte address is four times the index
	// ****************************************************************
	localparam logic [5:0] IDX_VEC_OUT   = 6'h03;
	localparam logic [5:0] IDX_VEC_LEN   = 6'h04;
	localparam logic [5:0] IDX_CONN_HOLD = 6'h06;
	localparam logic [5:0] IDX_LS_SEND   = 6'h07;
	localparam logic [5:0] IDX_BREAK     = 6'h08;
	localparam logic [5:0] IDX_SIG_TOUT  = 6'h09;
	localparam logic [5:0] IDX_CONF_LEN  = 6'h0b;
	localparam logic [5:0] IDX_SCRUB     = 6'h0c;
	localparam logic [5:0] IDX_NOISE     = 6'h0d;
	localparam logic [5:0] IDX_CONTROL   = 6'h10;
	localparam logic [5:0] IDX_STATUS    = 6'h11;
	localparam logic [5:0] IDX_VEC_IN    = 6'h16;
	localparam logic [5:0] IDX_EVENT     = 6'h17;

	// ****************************************************************
	// Field positions and widths
	// ****************************************************************
	localparam int          PARAM_W        = 16;
	localparam int          LEN_W          = 4;
	localparam int          CT_DIV_W       = 8;
	localparam int          NT_DIV_W       = 2;
	localparam int          CTRL_CT16_BIT  = 0;
	localparam int          CTRL_NT16_BIT  = 1;
	localparam int          STAT_SIG_BIT   = 0;
	localparam int          STAT_NOISE_BIT = 1;
	localparam int          EVT_ERR_BIT    = 0;
	localparam logic [1:0]  ADDR_ALIGN     = 2'h0;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [15:0] PARAM_RESET    = 16'h0000;
	localparam logic [15:0] VEC_RESET      = 16'h0000;
	localparam logic [3:0]  LEN_RESET      = 4'h0;
	localparam logic [31:0] RDATA_NONE     = 32'h0000_0000;

	// ****************************************************************
	// Timing: the timers count in base ticks of 80 ns
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int BASE_TICK_NS  = 80;
	localparam int BASE_TICK_CYC = (BASE_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Index of each timing parameter in the parameter array
	localparam int P_CONN_HOLD = 0;
	localparam int P_LS_SEND   = 1;
	localparam int P_BREAK     = 2;
	localparam int P_SIG_TOUT  = 3;
	localparam int P_CONF_LEN  = 4;
	localparam int P_SCRUB     = 5;
	localparam int P_NOISE     = 6;
	localparam int N_PARAMS    = 7;

endpackage

// ### testbench/ctb_regs_monitor.sv
`timescale 1ns/100ps
module ctb_regs_monitor
	import ctb_pkg::*;
#(
	parameter int TICK_CYC = BASE_TICK_CYC
) (
	// Clock and reset
	input  wire logic        clock_i,
	input  wire logic        arst_n_i,
	// APB slave side
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] prdata_o,
	input  wire logic        pready_o,
	input  wire logic        pslverr_o,
	// Line side
	input  wire logic        tx_halt_o,
	input  wire logic        tx_master_o,
	input  wire logic        signaling_o,
	input  wire logic        noise_expired_o
);
	// ****************************************************************
	// Port checks
	// ****************************************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);

	chk_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("pready high for more than one cycle");
	chk_ready_wait: assert property
		(psel_i && penable_i && !pready_o && !$past(penable_i) |=> pready_o)
		else $error("pready missing one cycle into the access phase");
	chk_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
		else $error("read data driven outside the answer cycle");
	chk_err_ready: assert property (pslverr_o |-> pready_o)
		else $error("error flag without pready");
	chk_tx_idle: assert property (!signaling_o |-> !tx_halt_o && !tx_master_o)
		else $error("line state sent while signaling is idle");
	chk_tx_onehot: assert property (signaling_o |-> tx_halt_o ^ tx_master_o)
		else $error("not exactly one line state while signaling");
	chk_sig_start: assert property
		(psel_i && penable_i && pwrite_i && pready_o && !pslverr_o && !signaling_o
		&& paddr_i == {IDX_VEC_OUT, ADDR_ALIGN} |=> signaling_o)
		else $error("vector write did not start signaling");
	chk_noise_pulse: assert property (noise_expired_o |=> !noise_expired_o)
		else $error("noise expiry longer than one cycle");
endmodule

bind ctb_regs ctb_regs_monitor #(.TICK_CYC(TICK_CYC)) mon_u (
	.clock_i(clock_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .tx_halt_o(tx_halt_o), .tx_master_o(tx_master_o),
	.signaling_o(signaling_o), .noise_expired_o(noise_expired_o)
);

// ### testbench/ctb_peer.sv
`timescale 1ns/100ps
module ctb_peer (
	// Clock and reset
	input  wire logic clock_i,
	input  wire logic arst_n_i,
	// Line from the device
	input  wire logic signaling_i,
	input  wire logic tx_halt_i,
	input  wire logic tx_master_i,
	input  wire logic invert_i,
	// Line back to the device
	output logic      rx_halt_o,
	output logic      rx_master_o
);
	// ****************************************************************
	// Neighbor echoes each bit back, inverted while invert_i is high
	// ****************************************************************
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_halt_o   <= 1'b0;
			rx_master_o <= 1'b1;
		end else if (signaling_i) begin
			rx_halt_o   <= tx_halt_i ^ invert_i;
			rx_master_o <= tx_master_i ^ invert_i;
		end else begin
			// Outside a frame the line carries no meaning; toggle so stale bits show
			rx_halt_o   <= ~rx_halt_o;
			rx_master_o <= ~rx_master_o;
		end
	end
endmodule

// ### testbench/connection_timing_and_bit_signal_regs_test.sv
`timescale 1ns/100ps
module connection_timing_and_bit_signal_regs_test;
	import ctb_pkg::*;
	localparam int         TC     = 2;
	localparam logic [5:0] RA [9] = '{IDX_VEC_OUT, IDX_VEC_LEN, IDX_CONN_HOLD, IDX_LS_SEND,
		IDX_BREAK, IDX_SIG_TOUT, IDX_CONF_LEN, IDX_SCRUB, IDX_NOISE};
	localparam logic [15:0] PV [9] = '{16'h0, 16'h0, 16'hffb2, 16'hfffe, 16'hff10, 16'heced,
		16'ha0a2, 16'hff6d, 16'he796};
	logic        clock_i      = 1'b0;
	logic        arst_n_i     = 1'b0;
	logic        psel_i       = 1'b0;
	logic        penable_i    = 1'b0;
	logic        pwrite_i     = 1'b0;
	logic [7:0]  paddr_i      = 8'h00;
	logic [31:0] pwdata_i     = 32'h0000_0000;
	logic        line_noise_i = 1'b0;
	logic        invert       = 1'b0;
	logic [31:0] prdata_o;
	logic        pready_o, pslverr_o, rx_halt, rx_master;
	logic        tx_halt_o, tx_master_o, signaling_o, noise_expired_o;
	int          n_mismatch   = 0;
	int          num_checks   = 0;

	ctb_regs #(.TICK_CYC(TC)) dut_u (
		.clock_i(clock_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .rx_halt_i(rx_halt),
		.rx_master_i(rx_master), .line_noise_i(line_noise_i), .tx_halt_o(tx_halt_o),
		.tx_master_o(tx_master_o), .signaling_o(signaling_o), .noise_expired_o(noise_expired_o));
	ctb_peer peer_u (
		.clock_i(clock_i), .arst_n_i(arst_n_i), .signaling_i(signaling_o),
		.tx_halt_i(tx_halt_o), .tx_master_i(tx_master_o), .invert_i(invert),
		.rx_halt_o(rx_halt), .rx_master_o(rx_master));

	// ****************************************************************
	// Bus and check tasks
	// ****************************************************************
	function automatic logic [7:0] ba(input logic [5:0] i);
		return {i, ADDR_ALIGN};
	endfunction

	task automatic end_sim();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic cmp(input string w, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", w, exp, got);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int i;
		i = 0;
		psel_i   <= 1'b1;
		pwrite_i <= wr;
		paddr_i  <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clock_i);
			i++;
		end while (pready_o !== 1'b1 && i < 16);
		q = prdata_o;
		e = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
		if (pready_o !== 1'b1) begin
			cmp("pready", 32'h1, 32'h0);
			end_sim();
		end
		@(posedge clock_i);
	endtask

	task automatic wr(input logic [5:0] x, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, ba(x), d, q, e);
	endtask

	task automatic rd(input string w, input logic [7:0] a, input logic [31:0] exp,
			input logic ee);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		cmp(w, exp, q);
		cmp({w, " error"}, {31'h0, ee}, {31'h0, e});
	endtask

	// Counts cycles while the watched output (sel: 0 signaling, 1 noise expiry) keeps lvl
	task automatic span(input string w, input logic sel, input logic lvl, input int lo,
			input int hi);
		int n;
		n = 0;
		while ((sel ? noise_expired_o : signaling_o) === lvl && n < 2000) begin
			@(posedge clock_i);
			n++;
		end
		cmp(w, 32'h1, 32'(n >= lo && n <= hi));
		if (n >= 2000) end_sim();
	endtask

	// ****************************************************************
	// Stimulus
	// ****************************************************************
	initial begin
		forever #25 clock_i = ~clock_i;
	end

	initial begin
		repeat (20) @(posedge clock_i);
		arst_n_i <= 1'b1;
		@(posedge clock_i);
		foreach (RA[k]) rd("reset value", ba(RA[k]), 32'h0, 1'b0);
		for (int k = 2; k < 9; k++) begin
			wr(RA[k], {16'ha5a5, PV[k]});
			rd("param", ba(RA[k]), {16'h0, PV[k]}, 1'b0);
		end
		rd("unmapped", 8'h08, 32'h0, 1'b1);
		rd("unaligned", 8'h19, 32'h0, 1'b1);
		wr(IDX_CONTROL, 32'h1);
		rd("control", ba(IDX_CONTROL), 32'h1, 1'b0);
		wr(IDX_VEC_LEN, 32'h2);
		rd("length", ba(IDX_VEC_LEN), 32'h2, 1'b0);
		wr(IDX_LS_SEND, 32'hfff8);
		invert <= 1'b1;
		wr(IDX_VEC_OUT, 32'h5);
		cmp("first line state", 32'h2, {30'h0, tx_halt_o, tx_master_o});
		span("test bit time", 1'b0, 1'b1, 24 * TC - 5, 24 * TC + 3);
		rd("received", ba(IDX_VEC_IN), 32'h2, 1'b0);
		invert <= 1'b0;
		wr(IDX_VEC_LEN, 32'hf);
		wr(IDX_VEC_OUT, 32'h8001);
		wr(IDX_VEC_OUT, 32'hffff);
		rd("vector kept", ba(IDX_VEC_OUT), 32'h8001, 1'b0);
		rd("access error", ba(IDX_EVENT), 32'h1, 1'b0);
		rd("error cleared", ba(IDX_EVENT), 32'h0, 1'b0);
		rd("status", ba(IDX_STATUS), 32'h1, 1'b0);
		wr(IDX_VEC_LEN, 32'h3);
		rd("length kept", ba(IDX_VEC_LEN), 32'hf, 1'b0);
		rd("length error", ba(IDX_EVENT), 32'h1, 1'b0);
		span("sixteen bits", 1'b0, 1'b1, 128 * TC - 40, 128 * TC + 3);
		rd("received", ba(IDX_VEC_IN), 32'h8001, 1'b0);
		wr(IDX_CONTROL, 32'h0);
		wr(IDX_VEC_LEN, 32'h0);
		wr(IDX_LS_SEND, 32'hffff);
		wr(IDX_VEC_OUT, 32'h1);
		span("normal bit time", 1'b0, 1'b1, 256 * TC - 5, 256 * TC + 3);
		wr(IDX_NOISE, 32'hfff0);
		for (int m = 0; m < 2; m++) begin
			wr(IDX_CONTROL, (m == 0) ? 32'h2 : 32'h0);
			line_noise_i <= 1'b1;
			span("noise time", 1'b1, 1'b0, (m * 48 + 16) * TC,
				(m * 48 + 16) * TC + 6);
			line_noise_i <= 1'b0;
			repeat (4) @(posedge clock_i);
		end
		end_sim();
	end
endmodule
